// ---- dcc_top.v ----
`timescale 1ns/1ps
`include "dcc_defs.vh"
// Two peripheral channels behind an AHB-Lite register slave
module dcc_top (
    input  wire        hclk,
    input  wire        hresetn,
    input  wire        ce,
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output wire [31:0] hrdata,
    output wire        hreadyout,
    output wire        hresp,
    input  wire [3:0]  timer_evt,
    input  wire [1:0]  uart_rx_valid,
    input  wire [1:0]  uart_tx_empty,
    input  wire        i2c_rx,
    input  wire        i2c_tx_empty,
    output wire        sys_bus_req,
    input  wire        sys_bus_grant,
    output wire [11:0] sys_addr,
    output wire [7:0]  sys_wdata,
    output wire        sys_wr,
    output wire        sys_rd,
    input  wire [7:0]  sys_rdata,
    output wire        irq
);
    // ------------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------------
    reg  [7:0]  ctl_reg   [0:1];
    reg  [7:0]  io_reg    [0:1];
    reg  [7:0]  hi_reg    [0:1];
    reg  [7:0]  start_reg [0:1];
    reg  [7:0]  end_reg   [0:1];
    reg  [1:0]  irq_stat_reg;
    reg  [1:0]  irq_en_reg;
    reg  [31:0] hrdata_reg;
    reg         wpend_reg;
    reg  [11:0] waddr_reg;
    reg  [9:0]  sync1_reg;
    reg  [9:0]  sync2_reg;
    reg         owner_reg;

    wire [1:0]  req;
    wire [1:0]  done;
    wire [1:0]  clear_en;
    wire [11:0] ch_addr  [0:1];
    wire [7:0]  ch_wdata [0:1];
    wire [1:0]  ch_wr;
    wire [1:0]  ch_rd;
    wire [11:0] cur      [0:1];
    wire [1:0]  grant;

    wire        take = hsel & hready & htrans[1];
    wire [11:0] a    = haddr[11:0];

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_reg;
    assign irq       = |(irq_stat_reg & irq_en_reg);

    // ------------------------------------------------------------------------
    // Pin synchronisers: timers, UART and I2C events
    // ------------------------------------------------------------------------
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync1_reg <= 10'h000;
            sync2_reg <= 10'h000;
        end else if (ce) begin
            sync1_reg <= {i2c_tx_empty, i2c_rx, uart_tx_empty, uart_rx_valid, timer_evt};
            sync2_reg <= sync1_reg;
        end
    end

    // ------------------------------------------------------------------------
    // System bus arbitration between channels
    // ------------------------------------------------------------------------
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            owner_reg <= 1'b0;
        else if (ce && !(req[owner_reg]))
            owner_reg <= req[0] ? 1'b0 : 1'b1;
    end
    assign sys_bus_req = |req;
    assign grant       = {sys_bus_grant & owner_reg, sys_bus_grant & ~owner_reg};
    assign sys_addr    = ch_addr[owner_reg];
    assign sys_wdata   = ch_wdata[owner_reg];
    assign sys_wr      = ch_wr[owner_reg];
    assign sys_rd      = ch_rd[owner_reg];

    // ------------------------------------------------------------------------
    // Channels
    // ------------------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_ch
            dcc_channel #(.CHANNEL(g)) u_ch (
                .hclk          (hclk),
                .hresetn       (hresetn),
                .ce            (ce),
                .ctl           (ctl_reg[g]),
                .io_low        (io_reg[g]),
                .start_addr    ({hi_reg[g][3:0], start_reg[g]}),
                .end_addr      ({hi_reg[g][7:4], end_reg[g]}),
                .timer_evt     (sync2_reg[3:0]),
                .uart_rx_valid (sync2_reg[5:4]),
                .uart_tx_empty (sync2_reg[7:6]),
                .i2c_rx        (sync2_reg[8]),
                .i2c_tx_empty  (sync2_reg[9]),
                .grant         (grant[g]),
                .rdata         (sys_rdata),
                .req           (req[g]),
                .addr          (ch_addr[g]),
                .wdata         (ch_wdata[g]),
                .wr            (ch_wr[g]),
                .rd            (ch_rd[g]),
                .cur_addr      (cur[g]),
                .done          (done[g]),
                .clear_en      (clear_en[g]),
                .busy          ()
            );
        end
    endgenerate

    // ------------------------------------------------------------------------
    // AHB-Lite register slave, zero wait states
    // ------------------------------------------------------------------------
    always @(posedge hclk or negedge hresetn) begin : p_regs
        integer i;
        if (!hresetn) begin
            for (i = 0; i < 2; i = i + 1) begin
                ctl_reg[i]   <= `DCC_CTL_RESET;
                io_reg[i]    <= 8'h00;
                hi_reg[i]    <= 8'h00;
                start_reg[i] <= 8'h00;
                end_reg[i]   <= 8'h00;
            end
            irq_stat_reg <= 2'h0;
            irq_en_reg   <= 2'h0;
            hrdata_reg   <= 32'h0000_0000;
            wpend_reg    <= 1'b0;
            waddr_reg    <= 12'h000;
        end else if (ce) begin
            if (hready) begin
                wpend_reg <= take & hwrite;
                waddr_reg <= a;
            end
            if (wpend_reg) begin
                case (waddr_reg)
                    `DCC_CH0_CTL_ADDR:   ctl_reg[0]   <= hwdata[7:0];
                    `DCC_CH0_IO_ADDR:    io_reg[0]    <= hwdata[7:0];
                    `DCC_CH0_HI_ADDR:    hi_reg[0]    <= hwdata[7:0];
                    `DCC_CH0_START_ADDR: start_reg[0] <= hwdata[7:0];
                    `DCC_CH0_END_ADDR:   end_reg[0]   <= hwdata[7:0];
                    `DCC_CH1_CTL_ADDR:   ctl_reg[1]   <= hwdata[7:0];
                    `DCC_CH1_IO_ADDR:    io_reg[1]    <= hwdata[7:0];
                    `DCC_CH1_HI_ADDR:    hi_reg[1]    <= hwdata[7:0];
                    `DCC_CH1_START_ADDR: start_reg[1] <= hwdata[7:0];
                    `DCC_CH1_END_ADDR:   end_reg[1]   <= hwdata[7:0];
                    `DCC_IRQ_EN_ADDR:    irq_en_reg   <= hwdata[1:0];
                    default: ;
                endcase
            end
            // Hardware single-pass disable follows any software write
            for (i = 0; i < 2; i = i + 1)
                if (clear_en[i])
                    ctl_reg[i][`DCC_CTL_EN] <= 1'b0;
            // Set wins over the clear in the same cycle
            irq_stat_reg <= (irq_stat_reg
                & ~((wpend_reg && waddr_reg == `DCC_IRQ_CLR_ADDR) ? hwdata[1:0] : 2'h0))
                | (done & {ctl_reg[1][`DCC_CTL_IRQ], ctl_reg[0][`DCC_CTL_IRQ]});
            if (take && !hwrite) begin
                case (a)
                    `DCC_CH0_CTL_ADDR:   hrdata_reg <= {24'h0, ctl_reg[0]};
                    `DCC_CH0_IO_ADDR:    hrdata_reg <= {24'h0, io_reg[0]};
                    `DCC_CH0_HI_ADDR:    hrdata_reg <= {24'h0, hi_reg[0]};
                    `DCC_CH0_START_ADDR: hrdata_reg <= {24'h0, cur[0][7:0]};
                    `DCC_CH0_END_ADDR:   hrdata_reg <= {24'h0, end_reg[0]};
                    `DCC_CH1_CTL_ADDR:   hrdata_reg <= {24'h0, ctl_reg[1]};
                    `DCC_CH1_IO_ADDR:    hrdata_reg <= {24'h0, io_reg[1]};
                    `DCC_CH1_HI_ADDR:    hrdata_reg <= {24'h0, hi_reg[1]};
                    `DCC_CH1_START_ADDR: hrdata_reg <= {24'h0, cur[1][7:0]};
                    `DCC_CH1_END_ADDR:   hrdata_reg <= {24'h0, end_reg[1]};
                    `DCC_IRQ_STAT_ADDR:  hrdata_reg <= {30'h0, irq_stat_reg};
                    `DCC_IRQ_EN_ADDR:    hrdata_reg <= {30'h0, irq_en_reg};
                    default:             hrdata_reg <= 32'h0000_0000;
                endcase
            end
        end
    end
endmodule // dcc_top

// ---- dcc_defs.vh ----
`ifndef DCC_DEFS_VH
`define DCC_DEFS_VH

// ----------------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------------
`define DCC_CH0_CTL_ADDR   12'hFB0
`define DCC_CH0_IO_ADDR    12'hFB1
`define DCC_CH0_HI_ADDR    12'hFB2
`define DCC_CH0_START_ADDR 12'hFB3
`define DCC_CH0_END_ADDR   12'hFB4
`define DCC_CH1_CTL_ADDR   12'hFB8
`define DCC_CH1_IO_ADDR    12'hFB9
`define DCC_CH1_HI_ADDR    12'hFBA
`define DCC_CH1_START_ADDR 12'hFBB
`define DCC_CH1_END_ADDR   12'hFBC
`define DCC_IRQ_STAT_ADDR  12'hFC0
`define DCC_IRQ_EN_ADDR    12'hFC4
`define DCC_IRQ_CLR_ADDR   12'hFC8

// ----------------------------------------------------------------------------
// Control field positions and reset values
// ----------------------------------------------------------------------------
`define DCC_CTL_EN    7
`define DCC_CTL_LOOP  6
`define DCC_CTL_DIR   5
`define DCC_CTL_IRQ   4
`define DCC_CTL_WORD  3
`define DCC_CTL_TRG_HI 2
`define DCC_CTL_TRG_LO 0
`define DCC_CTL_RESET 8'h00
`define DCC_PERIPH_PAGE 4'hF
`define DCC_TRG_RESERVED 3'h7

`endif

// ---- dcc_trigger_sel.v ----
`timescale 1ns/1ps
// Picks one channel's trigger from synchronised raw peripheral events
module dcc_trigger_sel #(
    parameter CHANNEL = 0
) (
    input  wire [2:0] sel,
    input  wire [3:0] timer_evt,
    input  wire [1:0] uart_rx_valid,
    input  wire [1:0] uart_tx_empty,
    input  wire       i2c_rx,
    input  wire       i2c_tx_empty,
    output reg        trig
);
    // ------------------------------------------------------------------------
    // Source multiplexer
    // ------------------------------------------------------------------------
    always @* begin
        case (sel)
            3'h0, 3'h1, 3'h2, 3'h3: trig = timer_evt[sel[1:0]];
            3'h4: trig = (CHANNEL == 0) ? uart_rx_valid[0] : uart_tx_empty[0];
            3'h5: trig = (CHANNEL == 0) ? uart_rx_valid[1] : uart_tx_empty[1];
            3'h6: trig = (CHANNEL == 0) ? i2c_rx : i2c_tx_empty;
            default: trig = 1'b0;
        endcase
    end
endmodule // dcc_trigger_sel

// ---- dcc_channel.v ----
`timescale 1ns/1ps
`include "dcc_defs.vh"
// One channel: trigger edge, bus handshake, data move and address step
module dcc_channel #(
    parameter CHANNEL = 0
) (
    input  wire        hclk,
    input  wire        hresetn,
    input  wire        ce,
    input  wire [7:0]  ctl,
    input  wire [7:0]  io_low,
    input  wire [11:0] start_addr,
    input  wire [11:0] end_addr,
    input  wire [3:0]  timer_evt,
    input  wire [1:0]  uart_rx_valid,
    input  wire [1:0]  uart_tx_empty,
    input  wire        i2c_rx,
    input  wire        i2c_tx_empty,
    input  wire        grant,
    input  wire [7:0]  rdata,
    output wire        req,
    output reg  [11:0] addr,
    output reg  [7:0]  wdata,
    output reg         wr,
    output reg         rd,
    output reg  [11:0] cur_addr,
    output reg         done,
    output reg         clear_en,
    output wire        busy
);
    localparam S_IDLE = 4'b0001;
    localparam S_REQ  = 4'b0010;
    localparam S_RD   = 4'b0100;
    localparam S_WR   = 4'b1000;

    reg  [3:0]  state_reg;
    reg         trig_reg;
    reg         second_reg;
    reg  [7:0]  hold_reg;
    wire        trig;
    wire        en   = ctl[`DCC_CTL_EN];
    wire        word = ctl[`DCC_CTL_WORD];
    wire        dir  = ctl[`DCC_CTL_DIR];
    wire [11:0] pa   = {`DCC_PERIPH_PAGE, io_low[7:1], io_low[0] | second_reg};
    wire [11:0] ra   = cur_addr + {11'h000, second_reg};

    dcc_trigger_sel #(.CHANNEL(CHANNEL)) u_sel (
        .sel           (ctl[`DCC_CTL_TRG_HI:`DCC_CTL_TRG_LO]),
        .timer_evt     (timer_evt),
        .uart_rx_valid (uart_rx_valid),
        .uart_tx_empty (uart_tx_empty),
        .i2c_rx        (i2c_rx),
        .i2c_tx_empty  (i2c_tx_empty),
        .trig          (trig)
    );

    assign req  = (state_reg != S_IDLE);
    assign busy = req;

    // ------------------------------------------------------------------------
    // Transfer sequencer
    // ------------------------------------------------------------------------
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg  <= S_IDLE;
            trig_reg   <= 1'b0;
            second_reg <= 1'b0;
            hold_reg   <= 8'h00;
            cur_addr   <= 12'h000;
            addr       <= 12'h000;
            wdata      <= 8'h00;
            wr         <= 1'b0;
            rd         <= 1'b0;
            done       <= 1'b0;
            clear_en   <= 1'b0;
        end else if (ce) begin
            trig_reg <= trig;
            wr       <= 1'b0;
            rd       <= 1'b0;
            done     <= 1'b0;
            clear_en <= 1'b0;
            case (state_reg)
                S_IDLE: begin
                    second_reg <= 1'b0;
                    if (!en)
                        cur_addr <= start_addr;     // Rearm from programmed start
                    else if (trig & ~trig_reg)
                        state_reg <= S_REQ;
                end
                S_REQ: if (grant) begin
                    addr      <= dir ? pa : ra;
                    rd        <= 1'b1;
                    state_reg <= S_RD;
                end
                S_RD: begin
                    hold_reg  <= rdata;              // Data valid in the same cycle as rd
                    state_reg <= S_WR;
                end
                default: begin
                    addr  <= dir ? ra : pa;
                    wdata <= hold_reg;
                    wr    <= 1'b1;
                    if (word && !second_reg) begin
                        second_reg <= 1'b1;          // Second byte reasks with bus still held
                        state_reg <= S_REQ;
                    end else begin
                        state_reg <= S_IDLE;
                        if (cur_addr == end_addr) begin
                            cur_addr <= start_addr;
                            done     <= 1'b1;
                            clear_en <= ~ctl[`DCC_CTL_LOOP];
                        end else
                            cur_addr <= cur_addr + (word ? 12'h002 : 12'h001);
                    end
                end
            endcase
        end
    end
endmodule // dcc_channel

// ---- dcc_checker.sv ----
`timescale 1ns/1ps
`include "dcc_defs.vh"
// ----------------------------------------------------------------
// Port checker for the channel pair
// ----------------------------------------------------------------
module dcc_checker (
    input wire        hclk,
    input wire        hresetn,
    input wire        hsel,
    input wire [31:0] haddr,
    input wire [1:0]  htrans,
    input wire        hwrite,
    input wire [31:0] hwdata,
    input wire        hready,
    input wire        sys_bus_req,
    input wire        sys_bus_grant,
    input wire [11:0] sys_addr,
    input wire [7:0]  sys_wdata,
    input wire        sys_wr,
    input wire        sys_rd,
    input wire [7:0]  sys_rdata,
    input wire        irq
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    reg        wph_reg;
    reg [11:0] wa_reg;
    reg [1:0]  en_reg;
    reg [1:0]  ien_reg;
    // Shadow of enable bits and interrupt mask, committed in the data phase
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wph_reg <= 1'b0;
            wa_reg  <= 12'h000;
            en_reg  <= 2'b00;
            ien_reg <= 2'b00;
        end else begin
            wph_reg <= hsel && hready && htrans[1] && hwrite;
            wa_reg  <= haddr[11:0];
            if (wph_reg && wa_reg == `DCC_CH0_CTL_ADDR) en_reg[0] <= hwdata[7];
            if (wph_reg && wa_reg == `DCC_CH1_CTL_ADDR) en_reg[1] <= hwdata[7];
            if (wph_reg && wa_reg == `DCC_IRQ_EN_ADDR) ien_reg <= hwdata[1:0];
        end
    end
    a_rd_after_grant: assert property (sys_rd |-> $past(sys_bus_grant) && $past(sys_bus_req))
        else $error("bus read without grant");
    a_wr_follows_rd: assert property (sys_rd |-> ##2 (sys_wr && sys_wdata == $past(sys_rdata, 2)))
        else $error("moved byte differs from byte read");
    a_periph_page: assert property (sys_rd |-> ##2 (sys_addr[11:8] == `DCC_PERIPH_PAGE
        || $past(sys_addr[11:8], 2) == `DCC_PERIPH_PAGE)) else $error("peripheral page missing");
    a_rd_wr_apart: assert property (!(sys_rd && sys_wr))
        else $error("read and write strobes together");
    a_rd_pulse: assert property (sys_rd |=> !sys_rd)
        else $error("read strobe longer than one cycle");
    a_idle_when_off: assert property (en_reg == 2'b00 && !sys_bus_req |=> !sys_bus_req)
        else $error("bus request while both channels off");
    a_bus_freed: assert property ($rose(sys_bus_req) |-> ##[1:60] !sys_bus_req)
        else $error("system bus not handed back");
    a_irq_masked: assert property (ien_reg == 2'b00 |-> !irq)
        else $error("interrupt with mask clear");
    c_move: cover property (sys_wr);
    c_word: cover property (sys_wr ##[1:4] sys_rd);
    c_irq: cover property ($rose(irq));
endmodule // dcc_checker

// ---- dcc_sysbus_model.sv ----
`timescale 1ns/1ps
// ----------------------------------------------------------------
// CPU side: bus owner and register file
// ----------------------------------------------------------------
module dcc_sysbus_model (
    input  wire        hclk,
    input  wire        hresetn,
    input  wire [2:0]  gdelay,
    input  wire        sys_bus_req,
    output reg         sys_bus_grant,
    input  wire [11:0] sys_addr,
    input  wire [7:0]  sys_wdata,
    input  wire        sys_wr,
    input  wire        sys_rd,
    output wire [7:0]  sys_rdata
);
    reg [7:0] mem [0:4095];
    reg [7:0] last_reg;
    reg [2:0] wait_reg;
    // Live read during the strobe, inverted stale value otherwise
    assign sys_rdata = sys_rd ? mem[sys_addr] : ~last_reg;
    // Grant after a chosen delay, held until the request drops
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sys_bus_grant <= 1'b0;
            wait_reg      <= 3'd0;
            last_reg      <= 8'h00;
        end else begin
            if (sys_rd) last_reg <= mem[sys_addr];
            if (sys_wr) mem[sys_addr] <= sys_wdata;
            if (!sys_bus_req) begin
                sys_bus_grant <= 1'b0;
                wait_reg      <= 3'd0;
            end else if (wait_reg >= gdelay) sys_bus_grant <= 1'b1;
            else wait_reg <= wait_reg + 3'd1;
        end
    end
endmodule // dcc_sysbus_model

// ---- dma_channel_control_tb.sv ----
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Self-checking bench for the channel pair
// ----------------------------------------------------------------
module dma_channel_control_tb;
    reg         hclk = 1'b0;
    reg         hresetn = 1'b0;
    reg         hsel = 1'b0;
    reg  [31:0] haddr = 32'h00000000;
    reg  [1:0]  htrans = 2'b00;
    reg         hwrite = 1'b0;
    reg  [31:0] hwdata = 32'h00000000;
    reg  [9:0]  evt = 10'h000;
    reg  [2:0]  gd = 3'h0;
    wire [31:0] hrdata;
    wire        hreadyout, req, gnt, wr, rd, irq;
    wire [11:0] sa;
    wire [7:0]  swd, srd;
    integer     n_fail = 0, cmp_count = 0, k, c;
    reg  [31:0] seed = 32'h00000053, rdv;
    reg  [7:0]  bm [0:4095];
    reg  [7:0]  ctl [0:1];
    reg  [11:0] cur [0:1], st [0:1], ea [0:1];
    reg  [1:0]  stat = 2'b00;
    always #12.5 hclk = ~hclk;
    dcc_top dcc_top_i (
        .hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(),
        .timer_evt(evt[3:0]), .uart_rx_valid(evt[5:4]), .uart_tx_empty(evt[7:6]),
        .i2c_rx(evt[8]), .i2c_tx_empty(evt[9]), .sys_bus_req(req), .sys_bus_grant(gnt),
        .sys_addr(sa), .sys_wdata(swd), .sys_wr(wr), .sys_rd(rd), .sys_rdata(srd), .irq(irq));
    dcc_sysbus_model dcc_sysbus_model_i (
        .hclk(hclk), .hresetn(hresetn), .gdelay(gd), .sys_bus_req(req), .sys_bus_grant(gnt),
        .sys_addr(sa), .sys_wdata(swd), .sys_wr(wr), .sys_rd(rd), .sys_rdata(srd));
    // Helpers: random step, compare, bus cycle, register address
    task next_rnd;
        begin
            seed = seed ^ (seed << 13);
            seed = seed ^ (seed >> 17);
            seed = seed ^ (seed << 5);
        end
    endtask
    task chk(input [31:0] seen, input [31:0] exp);
        begin
            cmp_count = cmp_count + 1;
            if (seen !== exp) begin
                n_fail = n_fail + 1;
                $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task ahb(input w, input [11:0] a, input [7:0] d);
        begin
            @(posedge hclk);
            hsel   <= 1'b1;
            htrans <= 2'b10;
            haddr  <= {20'h00000, a};
            hwrite <= w;
            @(posedge hclk);
            while (hreadyout !== 1'b1) @(posedge hclk);
            htrans <= 2'b00;
            hwdata <= {24'h000000, d};
            @(posedge hclk);
            while (hreadyout !== 1'b1) @(posedge hclk);
            rdv = hrdata;
        end
    endtask
    function [11:0] rg(input integer c, input [2:0] o);
        rg = {8'hFB, c[0], o};
    endfunction
    function [9:0] src_of(input integer c, input integer code);
        if (code < 4) src_of = 10'h001 << code;
        else if (code < 6) src_of = 10'h010 << (code - 4 + 2 * c);
        else src_of = 10'h100 << c;
    endfunction
    task setup(input integer c, input [7:0] cv, input [11:0] s, input [11:0] e);
        begin
            ahb(1, rg(c, 3'h0), 8'h00);
            ahb(1, rg(c, 3'h1), c ? 8'h40 : 8'h20);
            ahb(1, rg(c, 3'h2), {e[11:8], s[11:8]});
            ahb(1, rg(c, 3'h3), s[7:0]);
            ahb(1, rg(c, 3'h4), e[7:0]);
            ahb(1, rg(c, 3'h0), cv);
            ctl[c] = cv;
            st[c] = s;
            ea[c] = e;
            cur[c] = s;
        end
    endtask
    // One trigger, then the model's moves and register state compared
    task xfer(input integer c, input [9:0] src, input hit);
        integer n, j, w;
        reg [11:0] pa, ra;
        begin
            next_rnd;
            gd <= seed[2:0];
            evt <= src;
            repeat (4) @(posedge hclk);
            evt <= 10'h000;
            n = 0;
            repeat (80) begin
                @(negedge hclk);
                if (wr === 1'b1) n = n + 1;
            end
            w = (hit && ctl[c][7]) ? 1 + ctl[c][3] : 0;
            chk(n, w);
            for (j = 0; j < w; j = j + 1) begin
                pa = {4'hF, (c ? 8'h40 : 8'h20) | j[7:0]};
                ra = cur[c] + j[11:0];
                if (ctl[c][5]) bm[ra] = bm[pa];
                else bm[pa] = bm[ra];
                chk(32'(dcc_sysbus_model_i.mem[ctl[c][5] ? ra : pa]), 32'(bm[ctl[c][5] ? ra : pa]));
            end
            if (w != 0 && cur[c] == ea[c]) begin
                cur[c] = st[c];
                if (ctl[c][4]) stat[c] = 1'b1;
                if (!ctl[c][6]) ctl[c][7] = 1'b0;
            end else cur[c] = cur[c] + w[11:0];
            ahb(0, rg(c, 3'h3), 8'h00);
            chk(32'(rdv[7:0]), 32'(cur[c][7:0]));
            ahb(0, rg(c, 3'h0), 8'h00);
            chk(32'(rdv[7:0]), 32'(ctl[c]));
            ahb(0, 12'hFC0, 8'h00);
            chk(32'(rdv[1:0]), 32'(stat));
        end
    endtask
    task end_of_test;
        begin
            $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
            if (n_fail == 0 && cmp_count > 0)
                $display("TEST PASSED");
            else
                $display("TEST FAILED");
            $finish;
        end
    endtask
    // Watchdog against a hung handshake
    initial begin
        repeat (30000) @(posedge hclk);
        n_fail = n_fail + 1;
        end_of_test;
    end
    // Main sequence
    initial begin
        for (k = 0; k < 4096; k = k + 1) begin
            next_rnd;
            bm[k] = seed[7:0];
            dcc_sysbus_model_i.mem[k] = seed[7:0];
        end
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        ahb(0, 12'hFB0, 8'h00);
        chk(rdv, 32'h00000000);
        ahb(0, 12'hFB8, 8'h00);
        chk(rdv, 32'h00000000);
        ahb(0, 12'hFD0, 8'h00);
        chk(rdv, 32'h00000000);
        // Disabled channel, then enable with no fresh event
        setup(0, 8'h00, 12'h100, 12'h110);
        xfer(0, src_of(0, 0), 1);
        evt <= src_of(0, 0);
        ahb(1, 12'hFB0, 8'h80);
        ctl[0] = 8'h80;
        xfer(0, src_of(0, 0), 0);
        // Every trigger code on both channels, looping, no interrupt
        for (c = 0; c < 2; c = c + 1) begin
            setup(c, c ? 8'hC0 : 8'hE0, 12'h200 + 12'h040 * c[11:0], 12'h205 + 12'h040 * c[11:0]);
            for (k = 0; k < 7; k = k + 1) begin
                ctl[c] = {ctl[c][7:3], k[2:0]};
                ahb(1, rg(c, 3'h0), ctl[c]);
                xfer(c, src_of(c, (k + 1) % 7), 0);
                xfer(c, src_of(c, k), 1);
            end
            ctl[c] = ctl[c] | 8'h07;
            ahb(1, rg(c, 3'h0), ctl[c]);
            xfer(c, 10'h3FF, 0);
        end
        // Word, single pass with interrupt; mask and clear
        ahb(1, 12'hFC4, 8'h03);
        setup(1, 8'h98, 12'h300, 12'h302);
        xfer(1, src_of(1, 0), 1);
        xfer(1, src_of(1, 0), 1);
        setup(0, 8'hB8, 12'h3F0, 12'h3F0);
        xfer(0, src_of(0, 0), 1);
        chk(32'(irq), 32'h00000001);
        ahb(1, 12'hFC4, 8'h00);
        @(negedge hclk);
        chk(32'(irq), 32'h00000000);
        ahb(1, 12'hFC8, 8'h03);
        stat = 2'b00;
        xfer(1, src_of(1, 0), 1);
        end_of_test;
    end
endmodule // dma_channel_control_tb
bind dcc_top dcc_checker dcc_checker_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .sys_bus_req(sys_bus_req),
    .sys_bus_grant(sys_bus_grant), .sys_addr(sys_addr), .sys_wdata(sys_wdata),
    .sys_wr(sys_wr), .sys_rd(sys_rd), .sys_rdata(sys_rdata), .irq(irq));
